// file: rtl/lcfg_top.sv
// per-channel transmit template and receive path configuration registers over apb
`timescale 1ns/1ps
`include "lcfg_regs.svh"
module lcfg_top #(
    parameter int NCH = 4
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [9:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    input  wire logic [NCH-1:0][3:0]  tx_template_select,
    input  wire logic [NCH-1:0]       line_is_e1,
    output logic      [NCH-1:0][5:0]  pulse_amplitude_scale,
    output logic      [NCH-1:0][1:0]  scale_step_pct,
    output logic      [NCH-1:0]       user_template_active,
    output logic      [NCH-1:0]       rx_power_down,
    input  wire logic [NCH-1:0]       rx_recovered_clock,
    input  wire logic [NCH-1:0]       rx_slicer_pos,
    input  wire logic [NCH-1:0]       rx_slicer_neg,
    output logic      [NCH-1:0]       rx_single_rail_out,
    output logic      [NCH-1:0]       rx_positive_rail_out,
    output logic      [NCH-1:0]       rx_negative_rail_out
);
    // the ram address carries the channel in two bits, so four channels at most
    if (NCH < 1 || NCH > 4) begin : g_bad_nch
        $error("lcfg_top: NCH must be 1 to 4");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [NCH-1:0][5:0] scale;
        logic [NCH-1:0]      go;
        logic [NCH-1:0]      rd;
        logic [NCH-1:0][1:0] ui;
        logic [NCH-1:0][3:0] smp;
        logic [NCH-1:0][6:0] tdat;
        logic [NCH-1:0][4:0] rxcfg;
        lcfg_pkg::lcfg_st_t  st;
        logic [1:0]          cur;
        logic [31:0]         rdat;
        logic                err;
        logic [NCH-1:0][5:0] sc_o;
        logic [NCH-1:0][1:0] pct_o;
        logic [NCH-1:0]      act_o;
        logic [NCH-1:0]      pd_o;
        logic [NCH-1:0]      ck_s1;
        logic [NCH-1:0]      ck_s2;
        logic [NCH-1:0]      ck_s3;
        logic [NCH-1:0]      p_s1;
        logic [NCH-1:0]      p_s2;
        logic [NCH-1:0]      n_s1;
        logic [NCH-1:0]      n_s2;
        logic [NCH-1:0]      lastpol;
        logic [NCH-1:0]      kill;
        logic [NCH-1:0][3:0] sh;
        logic [NCH-1:0]      rd_o;
        logic [NCH-1:0]      rp_o;
        logic [NCH-1:0]      rn_o;
    } lcfg_state_t;

    lcfg_state_t s_r;
    lcfg_state_t s_nxt;

    logic [7:0] idx;
    logic [1:0] ch_sel;
    logic [5:0] reg_sel;
    logic       ch_ok;
    logic       mapped;
    logic       ram_en;
    logic       ram_we;
    logic [7:0] ram_addr;
    logic [6:0] ram_wdata;
    logic [6:0] ram_rdata;

    assign idx     = paddr[9:2];
    assign ch_sel  = idx[7:6];
    assign reg_sel = idx[5:0];
    assign ch_ok   = 32'(ch_sel) < NCH;
    // each channel window spans 64 index steps, the channel number sits above them
    assign mapped  = ch_ok && (reg_sel >= `LCFG_IDX_SCALE) && (reg_sel <= `LCFG_IDX_RXCFG);

    // zero wait: read data are prepared in the setup cycle
    assign pready  = psel & penable;

    // ****************************************************************
    // template memory port
    // ****************************************************************
    assign ram_en    = (s_r.st == lcfg_pkg::LCFG_ISSUE);
    assign ram_we    = ~s_r.rd[s_r.cur];
    assign ram_addr  = {s_r.cur, s_r.ui[s_r.cur], s_r.smp[s_r.cur]};
    assign ram_wdata = s_r.tdat[s_r.cur];

    lcfg_tpl_ram #(
        .AW (8),
        .DW (7)
    ) u_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (ram_en),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (ram_wdata),
        .rdata   (ram_rdata)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic pulse;
        logic viol;
        logic ev;
        logic inv;
        logic [1:0] md;
        pulse = 1'b0;
        viol  = 1'b0;
        ev    = 1'b0;
        inv   = 1'b0;
        md    = 2'h0;
        s_nxt = s_r;

        // apb setup: latch answer; access: commit write
        if (psel && !penable) begin
            s_nxt.err  = ~mapped;
            s_nxt.rdat = 32'h0;
            if (mapped) begin
                if (reg_sel == `LCFG_IDX_SCALE) begin
                    s_nxt.rdat[5:0] = s_r.scale[ch_sel];
                end else if (reg_sel == `LCFG_IDX_ACCESS) begin
                    s_nxt.rdat[7:0] = {s_r.go[ch_sel], s_r.rd[ch_sel],
                                       s_r.ui[ch_sel], s_r.smp[ch_sel]};
                end else if (reg_sel == `LCFG_IDX_TDATA) begin
                    s_nxt.rdat[6:0] = s_r.tdat[ch_sel];
                end else begin
                    s_nxt.rdat[4:0] = s_r.rxcfg[ch_sel];
                end
            end
        end
        if (psel && penable && pwrite && mapped) begin
            if (reg_sel == `LCFG_IDX_SCALE) begin
                s_nxt.scale[ch_sel] = pwdata[5:0];
            end else if (reg_sel == `LCFG_IDX_ACCESS) begin
                // fields are frozen while an access is in flight
                if (!s_r.go[ch_sel]) begin
                    s_nxt.go[ch_sel]  = pwdata[`LCFG_ACC_GO_BIT];
                    s_nxt.rd[ch_sel]  = pwdata[`LCFG_ACC_RD_BIT];
                    s_nxt.ui[ch_sel]  = pwdata[5:4];
                    s_nxt.smp[ch_sel] = pwdata[3:0];
                end
            end else if (reg_sel == `LCFG_IDX_TDATA) begin
                s_nxt.tdat[ch_sel] = pwdata[6:0];
            end else begin
                s_nxt.rxcfg[ch_sel] = pwdata[4:0];
            end
        end

        // indirect access sequencer, lowest pending channel first
        case (s_r.st)
            lcfg_pkg::LCFG_IDLE: begin
                for (int c = NCH - 1; c >= 0; c--) begin
                    if (s_r.go[c]) begin
                        s_nxt.cur = 2'(c);
                        s_nxt.st  = lcfg_pkg::LCFG_ISSUE;
                    end
                end
            end
            lcfg_pkg::LCFG_ISSUE: begin
                s_nxt.st = lcfg_pkg::LCFG_WAIT;
            end
            default: begin
                // a read completion overrides a same-cycle software write to the data field
                if (s_r.rd[s_r.cur]) begin
                    s_nxt.tdat[s_r.cur] = ram_rdata;
                end
                s_nxt.go[s_r.cur] = 1'b0;
                s_nxt.st          = lcfg_pkg::LCFG_IDLE;
            end
        endcase

        for (int c = 0; c < NCH; c++) begin
            // transmit side settings only matter for a user template
            s_nxt.act_o[c] = tx_template_select[c][3:2] == `LCFG_TPL_USER_TOP;
            s_nxt.sc_o[c]  = s_nxt.act_o[c] ? s_r.scale[c] : 6'h00;
            s_nxt.pct_o[c] = line_is_e1[c] ? `LCFG_STEP_PCT_E1
                                           : `LCFG_STEP_PCT_T1;

            // pins pass two flops before use
            s_nxt.ck_s1[c] = rx_recovered_clock[c];
            s_nxt.ck_s2[c] = s_r.ck_s1[c];
            s_nxt.ck_s3[c] = s_r.ck_s2[c];
            s_nxt.p_s1[c]  = rx_slicer_pos[c];
            s_nxt.p_s2[c]  = s_r.p_s1[c];
            s_nxt.n_s1[c]  = rx_slicer_neg[c];
            s_nxt.n_s2[c]  = s_r.n_s1[c];

            inv = s_r.rxcfg[c][`LCFG_RX_INV_BIT];
            md  = s_r.rxcfg[c][1:0];
            ev  = s_r.rxcfg[c][`LCFG_RX_EDGE_BIT]
                ? (s_r.ck_s3[c] & ~s_r.ck_s2[c])
                : (s_r.ck_s2[c] & ~s_r.ck_s3[c]);
            pulse = s_r.p_s2[c] | s_r.n_s2[c];
            viol  = pulse && (s_r.p_s2[c] == s_r.lastpol[c]);
            s_nxt.pd_o[c] = s_r.rxcfg[c][`LCFG_RX_PD_BIT];

            if (s_r.rxcfg[c][`LCFG_RX_PD_BIT]) begin
                // powered down: outputs rest at the no-data level
                s_nxt.sh[c]   = 4'h0;
                s_nxt.kill[c] = 1'b0;
                s_nxt.rd_o[c] = inv;
                s_nxt.rp_o[c] = inv;
                s_nxt.rn_o[c] = inv;
            end else if (md == `LCFG_RXM_SLICE) begin
                // slicer mode follows the rails every cycle, edge select unused
                s_nxt.rd_o[c] = inv;
                s_nxt.rp_o[c] = s_r.p_s2[c] ^ inv;
                s_nxt.rn_o[c] = s_r.n_s2[c] ^ inv;
            end else if (ev) begin
                if (md == `LCFG_RXM_DUAL) begin
                    s_nxt.rd_o[c] = inv;
                    s_nxt.rp_o[c] = s_r.p_s2[c] ^ inv;
                    s_nxt.rn_o[c] = s_r.n_s2[c] ^ inv;
                end else begin
                    // four-bit delay lets a code substitution be removed after the fact
                    s_nxt.rd_o[c] = s_r.sh[c][3] ^ inv;
                    s_nxt.rp_o[c] = inv;
                    s_nxt.rn_o[c] = inv;
                    s_nxt.sh[c]   = {s_r.sh[c][2:0], pulse};
                    s_nxt.kill[c] = 1'b0;
                    if (md == `LCFG_RXM_HDB3) begin
                        if (viol && line_is_e1[c]) begin
                            s_nxt.sh[c] = 4'h0;
                        end else if (viol) begin
                            s_nxt.sh[c][0] = 1'b0;
                            s_nxt.kill[c]  = 1'b1;
                        end else if (s_r.kill[c]) begin
                            s_nxt.sh[c][0] = 1'b0;
                        end
                    end
                end
                if (pulse) begin
                    s_nxt.lastpol[c] = s_r.p_s2[c];
                end
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r       <= '0;
            s_r.scale <= {NCH{`LCFG_SCALE_RST}};
            s_r.tdat  <= {NCH{`LCFG_TDATA_RST}};
            s_r.rxcfg <= {NCH{`LCFG_RXCFG_RST}};
            s_r.st    <= lcfg_pkg::LCFG_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata                = s_r.rdat;
    assign pslverr               = s_r.err & psel & penable;
    assign pulse_amplitude_scale = s_r.sc_o;
    assign scale_step_pct        = s_r.pct_o;
    assign user_template_active  = s_r.act_o;
    assign rx_power_down         = s_r.pd_o;
    assign rx_single_rail_out    = s_r.rd_o;
    assign rx_positive_rail_out  = s_r.rp_o;
    assign rx_negative_rail_out  = s_r.rn_o;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    go_completes_a: assert property ($rose(s_r.go[0]) |-> ##[2:16] !s_r.go[0])
        else $error("template access did not complete");
    ram_write_a: assert property (ram_en && !s_r.rd[s_r.cur]
        |=> u_ram.s_r.mem[$past(ram_addr)] == $past(s_r.tdat[s_r.cur]))
        else $error("indirect write data wrong");
    ram_addr_a: assert property (ram_en && s_r.rd[s_r.cur]
        |=> ram_rdata == u_ram.s_r.mem[{$past(s_r.cur), $past(s_r.ui[s_r.cur]),
                                        $past(s_r.smp[s_r.cur])}])
        else $error("template address wrong");
    read_back_a: assert property (s_r.st == lcfg_pkg::LCFG_WAIT && s_r.rd[s_r.cur]
        |=> s_r.tdat[$past(s_r.cur)] == $past(ram_rdata))
        else $error("read data not returned");
    scale_gate_a: assert property (tx_template_select[0][3:2] != `LCFG_TPL_USER_TOP
        |=> pulse_amplitude_scale[0] == 6'h00)
        else $error("scale applied without user template");
    step_pct_a: assert property (line_is_e1[0]
        |=> scale_step_pct[0] == `LCFG_STEP_PCT_E1)
        else $error("E1 step size wrong");
    power_down_a: assert property (s_r.rxcfg[0][`LCFG_RX_PD_BIT]
        |=> rx_positive_rail_out[0] == $past(s_r.rxcfg[0][`LCFG_RX_INV_BIT]))
        else $error("receiver output active in power down");
    slicer_path_a: assert property (s_r.rxcfg[0][1:0] == `LCFG_RXM_SLICE
        && !s_r.rxcfg[0][`LCFG_RX_PD_BIT]
        |=> rx_negative_rail_out[0] == ($past(s_r.n_s2[0]) ^ $past(s_r.rxcfg[0][3])))
        else $error("slicer data not passed");
    busy_freeze_a: assert property (s_r.go[0] && s_r.st == lcfg_pkg::LCFG_IDLE
        |=> $stable(s_r.ui[0]) && $stable(s_r.smp[0]))
        else $error("access address changed while busy");
endmodule

// file: rtl/lcfg_regs.svh
// register offsets, field positions, reset values and codes of the line config block
`ifndef LCFG_REGS_SVH
`define LCFG_REGS_SVH

// register indices within one channel; byte address is four times the index
`define LCFG_IDX_SCALE      6'h04
`define LCFG_IDX_ACCESS     6'h05
`define LCFG_IDX_TDATA      6'h06
`define LCFG_IDX_RXCFG      6'h07
// channel copies step by this many indices
`define LCFG_CH_STEP        8'h40

// template access register fields
`define LCFG_ACC_GO_BIT     7
`define LCFG_ACC_RD_BIT     6
// receive configuration fields
`define LCFG_RX_PD_BIT      4
`define LCFG_RX_INV_BIT     3
`define LCFG_RX_EDGE_BIT    2

// reset values
`define LCFG_SCALE_RST      6'h21
`define LCFG_TDATA_RST      7'h00
`define LCFG_RXCFG_RST      5'h00

// receive decode modes
`define LCFG_RXM_HDB3       2'h0
`define LCFG_RXM_AMI        2'h1
`define LCFG_RXM_DUAL       2'h2
`define LCFG_RXM_SLICE      2'h3

// template select codes
`define LCFG_TPL_USER_TOP   2'h3
`define LCFG_TPL_E1_75_INT  4'h0
`define LCFG_TPL_E1_75_EXT  4'h1
// recommended scaling values and amplitude change per step in percent
`define LCFG_SCALE_T1_REC   6'h36
`define LCFG_SCALE_E1_REC   6'h21
`define LCFG_STEP_PCT_T1    2'h2
`define LCFG_STEP_PCT_E1    2'h3

`endif

// file: rtl/lcfg_pkg.sv
// types shared by the line config block
package lcfg_pkg;
    // indirect template access sequencer
    typedef enum logic [1:0] {
        LCFG_IDLE,
        LCFG_ISSUE,
        LCFG_WAIT
    } lcfg_st_t;
endpackage

// file: rtl/lcfg_tpl_ram.sv
// pulse template memory with registered read data
`timescale 1ns/1ps
module lcfg_tpl_ram #(
    parameter int AW = 8,
    parameter int DW = 7
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    // elaboration-time guard against a geometry the memory cannot hold
    if (AW < 1 || DW < 1) begin : g_bad_geometry
        $error("lcfg_tpl_ram: bad geometry");
    end

    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0]              rd;
    } lcfg_ram_t;

    lcfg_ram_t s_r;
    lcfg_ram_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (en && we) begin
            s_nxt.mem[addr] = wdata;
        end
        if (en && !we) begin
            s_nxt.rd = s_r.mem[addr];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rd;
endmodule

// file: verif/lcfg_host_model.sv
// apb master standing in for the host processor
`timescale 1ns/1ps
module lcfg_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [9:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic      [31:0] rdata,
    output logic             err,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [9:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // ****************************************
    // one transfer per start pulse
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 10'h000;
            pwdata <= 32'h00000000;
            done <= 1'b0;
            rdata <= 32'h00000000;
            err <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !psel) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= wdata;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                rdata <= prdata;
                err <= pslverr;
                done <= 1'b1;
                // a released bus never shows the last write data
                pwdata <= ~pwdata;
            end
        end
    end
endmodule

// file: verif/lcfg_top_tb_top.sv
// self-checking bench of the line config register block
`timescale 1ns/1ps
`include "lcfg_regs.svh"
module lcfg_top_tb_top;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic            h_start, h_wr, h_done, h_err, rclk;
    logic [9:0]      paddr, h_addr;
    logic [31:0]     pwdata, prdata, h_wdata, h_rdata;
    logic [3:0][3:0] tsel;
    logic [3:0][5:0] scl;
    logic [3:0][1:0] pct;
    logic [3:0]      e1, sp, sn, pdn, act, rs, rp, rn;
    logic [2:0]      rc_cnt;
    int              error_cnt, check_count, cyc;

    lcfg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tx_template_select(tsel), .line_is_e1(e1),
        .pulse_amplitude_scale(scl), .scale_step_pct(pct), .user_template_active(act),
        .rx_power_down(pdn), .rx_recovered_clock({4{rclk}}), .rx_slicer_pos(sp),
        .rx_slicer_neg(sn), .rx_single_rail_out(rs), .rx_positive_rail_out(rp),
        .rx_negative_rail_out(rn));
    lcfg_host_model i_host (.pclk(pclk), .presetn(presetn), .start(h_start), .wr(h_wr),
        .addr(h_addr), .wdata(h_wdata), .done(h_done), .rdata(h_rdata), .err(h_err),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // ****************************************
    // clocks, line clock and hang guard
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        rc_cnt <= rc_cnt + 3'd1;
        if (rc_cnt == 3'd7) rclk <= ~rclk;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [9:0] ra(input logic [1:0] c, input logic [5:0] i);
        return {c, i, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        h_wr <= w;
        h_addr <= a;
        h_wdata <= d;
        h_start <= 1'b1;
        @(posedge pclk);
        h_start <= 1'b0;
        // no local limit: a slave that never answers runs into the cycle ceiling
        while (h_done !== 1'b1) @(posedge pclk);
    endtask
    task automatic launch(input logic [1:0] c, input logic [7:0] acc);
        int n;
        apb(1'b1, ra(c, `LCFG_IDX_ACCESS), {24'h0, acc});
        n = 0;
        do begin
            apb(1'b0, ra(c, `LCFG_IDX_ACCESS), 32'h0);
            n++;
        end while (h_rdata[7] !== 1'b0 && n < 10);
        chk({31'h0, h_rdata[7]}, 32'h0);
    endtask
    task automatic rx_cfg(input logic [4:0] v);
        apb(1'b1, ra(2'd0, `LCFG_IDX_RXCFG), {27'h0, v});
    endtask
    // pins move mid-phase of the line clock so the chosen edge sees settled data
    task automatic rx_set(input logic p, input logic n, input logic hi);
        do @(posedge pclk); while (!(rc_cnt == 3'd3 && rclk == hi));
        sp <= {4{p}};
        sn <= {4{n}};
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, ra(c[1:0], `LCFG_IDX_SCALE), 32'h0);
            chk(h_rdata, 32'h00000021);
            for (int i = 5; i < 8; i++) begin
                apb(1'b0, ra(c[1:0], 6'(i)), 32'h0);
                chk({h_rdata[30:0], h_err}, 32'h0);
            end
        end
        $display("test reset done");
    endtask
    task automatic t_chan();
        for (int c = 0; c < 4; c++) apb(1'b1, ra(c[1:0], `LCFG_IDX_RXCFG), 32'h1C ^ c);
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, ra(c[1:0], `LCFG_IDX_RXCFG), 32'h0);
            chk(h_rdata, 32'h1C ^ c);
        end
        apb(1'b1, ra(2'd0, 6'h08), 32'hFF);
        chk({31'h0, h_err}, 32'h1);
        apb(1'b0, ra(2'd0, 6'h08), 32'h0);
        chk({h_rdata[30:0], h_err}, 32'h1);
        $display("test channels done");
    endtask
    task automatic t_scale();
        tsel <= {4{4'hC}};
        e1 <= 4'b0101;
        apb(1'b1, ra(2'd1, `LCFG_IDX_SCALE), 32'h36);
        repeat (2) @(posedge pclk);
        chk({24'h0, scl[1], pct[1]}, {24'h0, 6'h36, 2'd2});
        chk({24'h0, scl[0], pct[0]}, {24'h0, 6'h21, 2'd3});
        chk({28'h0, act}, 32'hF);
        tsel <= {4'hF, 4'h3, `LCFG_TPL_E1_75_EXT, `LCFG_TPL_E1_75_INT};
        repeat (2) @(posedge pclk);
        chk({16'h0, act, scl[0], scl[3]}, {16'h0, 4'h8, 6'h00, 6'h21});
        $display("test scaling done");
    endtask
    task automatic t_tpl();
        logic [6:0] d;
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 16; k++) begin
                d = 7'(k * 7 + 5);
                apb(1'b1, ra(k[1:0], `LCFG_IDX_TDATA), (r == 0) ? {25'h0, d} : 32'h0);
                launch(k[1:0], {1'b1, r[0], {2{k[3]}}, {4{k[2]}}});
                if (r == 1) begin
                    apb(1'b0, ra(k[1:0], `LCFG_IDX_TDATA), 32'h0);
                    chk(h_rdata, {25'h0, d});
                end
            end
        end
        $display("test template done");
    endtask
    task automatic t_rx();
        logic v;
        for (int iv = 0; iv < 2; iv++) begin
            v = iv[0];
            // first pass decodes as E1, second as T1 so both substitution codes run
            e1 <= {e1[3:1], ~v};
            rx_cfg({1'b0, v, 1'b0, 2'b11});
            rx_set(1'b1, 1'b0, 1'b0);
            repeat (6) @(posedge pclk);
            chk({30'h0, rp[0], rn[0]}, {30'h0, ~v, v});
            rx_cfg({1'b0, v, 1'b0, 2'b10});
            rx_set(1'b0, 1'b1, 1'b0);
            repeat (20) @(posedge pclk);
            chk({30'h0, rp[0], rn[0]}, {30'h0, v, ~v});
            rx_set(1'b1, 1'b0, 1'b1);
            repeat (12) @(posedge pclk);
            chk({30'h0, rp[0], rn[0]}, {30'h0, v, ~v});
            repeat (8) @(posedge pclk);
            chk({30'h0, rp[0], rn[0]}, {30'h0, ~v, v});
            rx_cfg({1'b0, v, 1'b1, 2'b10});
            rx_set(1'b0, 1'b1, 1'b1);
            repeat (12) @(posedge pclk);
            chk({30'h0, rp[0], rn[0]}, {30'h0, v, ~v});
            for (int m = 0; m < 2; m++) begin
                rx_cfg({1'b0, v, 2'b00, m[0]});
                for (int j = 0; j < 8; j++) rx_set(~j[0], j[0], 1'b0);
                repeat (10) @(posedge pclk);
                chk({29'h0, rs[0], rp[0], rn[0]}, {29'h0, ~v, v, v});
                // same-polarity marks are violations, removed only by the substitution decoders
                for (int j = 0; j < 8; j++) rx_set(1'b0, 1'b1, 1'b0);
                repeat (10) @(posedge pclk);
                chk({31'h0, rs[0]}, {31'h0, m[0] ^ v});
                for (int j = 0; j < 8; j++) rx_set(1'b0, 1'b0, 1'b0);
                repeat (10) @(posedge pclk);
                chk({29'h0, rs[0], rp[0], rn[0]}, {29'h0, v, v, v});
            end
            rx_cfg({1'b1, v, 1'b0, 2'b11});
            rx_set(1'b1, 1'b0, 1'b0);
            repeat (6) @(posedge pclk);
            chk({28'h0, pdn[0], rs[0], rp[0], rn[0]}, {28'h0, 1'b1, v, v, v});
        end
        $display("test receive done");
    endtask

    initial begin
        presetn <= 1'b0;
        h_start <= 1'b0;
        h_wr <= 1'b0;
        h_addr <= 10'h000;
        h_wdata <= 32'h0;
        tsel <= 16'h0;
        e1 <= 4'h0;
        sp <= 4'h0;
        sn <= 4'h0;
        rclk <= 1'b0;
        rc_cnt <= 3'd0;
        cyc <= 0;
        error_cnt = 0;
        check_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_chan();
        t_scale();
        t_tpl();
        t_rx();
        end_of_test();
    end
endmodule
